//--- common/flgt_pkg.sv
/*
 * Shared constants, types and helpers for the fader-linked control port block.
 * Assumes one 125 MHz clock and fader level codes where 0 means silence.
 */
package flgt_pkg;

	localparam int NUM_IN = 8;
	localparam int NUM_OUT = 10;
	localparam int OUT_IW = 4;
	localparam int FADER_AW = 6;
	localparam int FADER_N = 64;
	localparam int LVL_W = 8;

	// register byte offsets; OFS_CFG_PAGE is the config page number in paddr[7:6]
	localparam logic [7:0] OFS_IN_POL = 8'h00;
	localparam logic [7:0] OFS_IN_LATCH = 8'h04;
	localparam logic [7:0] OFS_IN_STATE = 8'h08;
	localparam logic [7:0] OFS_OUT_POL = 8'h0c;
	localparam logic [7:0] OFS_OUT_TEST = 8'h10;
	localparam logic [7:0] OFS_OUT_STATE = 8'h14;
	localparam logic [7:0] OFS_THRESH = 8'h18;
	localparam logic [7:0] OFS_SEL_CTRL = 8'h1c;
	localparam logic [1:0] OFS_CFG_PAGE = 2'h1;

	// field positions
	localparam int THR_UP_LSB = 0;
	localparam int THR_DN_LSB = 8;
	localparam int SEL_EN_BIT = 0;
	localparam int SEL_TGT_LSB = 8;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_FADER_LSB = 8;

	// reset values
	localparam logic [NUM_IN-1:0] RST_IN_POL = 8'hff;
	localparam logic [NUM_IN-1:0] RST_IN_LATCH = 8'h00;
	localparam logic [NUM_OUT-1:0] RST_OUT_POL = 10'h000;
	localparam logic [LVL_W-1:0] RST_THR_UP = 8'h40;
	localparam logic [LVL_W-1:0] RST_THR_DN = 8'h00;

	// timing
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 1000;
	localparam int PULSE_MS = 250;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam logic [7:0] PULSE_TICKS = 8'((PULSE_MS * 1000) / TICK_US);

	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_START,
		MODE_STOP,
		MODE_TALLY
	} flgt_mode_t;

	function automatic logic cross_up(input logic [LVL_W-1:0] prev, input logic [LVL_W-1:0] cur,
		input logic [LVL_W-1:0] thr);
		return (prev < thr) && (cur >= thr);
	endfunction

	function automatic logic reach_down(input logic [LVL_W-1:0] prev,
		input logic [LVL_W-1:0] cur, input logic [LVL_W-1:0] thr);
		return (prev > thr) && (cur <= thr);
	endfunction

endpackage

//--- hdl/flgt_fader_mem.sv
/*
 * Fader level store: one write port from the mixer core, one registered read port.
 * Assumes writes and reads are synchronous to pclk; read data appear one cycle after rd_en.
 */
`timescale 1ns/1ps
module flgt_fader_mem (
	input wire logic pclk,
	input wire logic we,
	input wire logic [flgt_pkg::FADER_AW-1:0] waddr,
	input wire logic [flgt_pkg::LVL_W-1:0] wdata,
	input wire logic rd_en,
	input wire logic [flgt_pkg::FADER_AW-1:0] raddr,
	output logic [flgt_pkg::LVL_W-1:0] rdata_q
);
	logic [flgt_pkg::LVL_W-1:0] mem [flgt_pkg::FADER_N];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// write-first is not offered: a same-cycle read sees the old level
	always_ff @(posedge pclk) begin
		if (rd_en) begin
			rdata_q <= mem[raddr];
		end
	end
endmodule

//--- hdl/flgt_top.sv
/*
 * Control port logic: polarity and latch handling of the control inputs, and ten
 * control outputs driven by fader-linked trigger generators, all reached over APB.
 * Assumes the mixer core writes fader levels (final targets on a scene recall)
 * into the fader port and pulses recall_pulse once the targets are written.
 */
`timescale 1ns/1ps
// Function
// - low-active input counts as asserted while its level is low.
// - high-active input counts as asserted while its level is high.
// - low-active output grounds when asserted; high-active releases when asserted.
// - test bit forces its output asserted, overriding trigger logic.
// - each input is latching (toggle per press) or momentary.
// - ten outputs, each with own mode, fader, polarity and test bit.
// - each output compares its own selected fader against shared thresholds.
// - with assign-by-select on, a select key sets the target output's fader.
// - unassigned mode never changes the output.
// - start mode gives one 250 ms pulse on upward threshold crossing.
// - stop mode gives one 250 ms pulse on reaching downward threshold.
// - tally holds from upward crossing until downward threshold or any config write to that output.
// - one upward and one downward threshold shared by all outputs.
// - start uses upward only, stop downward only, tally both.
// - scene recall evaluates at once against final target levels.
module flgt_top #(
	parameter int TICK_CYCLES = flgt_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [flgt_pkg::NUM_IN-1:0] gpi_in,
	output logic [flgt_pkg::NUM_IN-1:0] gpi_state,
	output logic [flgt_pkg::NUM_OUT-1:0] gpo_o,
	output logic [flgt_pkg::NUM_OUT-1:0] gpo_oe,
	input wire logic fader_we,
	input wire logic [flgt_pkg::FADER_AW-1:0] fader_addr,
	input wire logic [flgt_pkg::LVL_W-1:0] fader_level,
	input wire logic recall_pulse,
	input wire logic sel_key,
	input wire logic [flgt_pkg::FADER_AW-1:0] sel_chan
);
	localparam int NI = flgt_pkg::NUM_IN;
	localparam int NO = flgt_pkg::NUM_OUT;
	localparam int LW = flgt_pkg::LVL_W;

	typedef enum logic [1:0] {SCAN_IDLE, SCAN_READ, SCAN_EVAL} flgt_scan_t;

	logic [NI-1:0] in_pol_q, in_latch_q, in_state_q, in_state_d, act_in, act_prev_q;
	logic [NO-1:0] out_pol_q, out_test_q, tally_q, pulse_on, act_out, cfg_wr;
	logic [LW-1:0] thr_up_q, thr_dn_q;
	logic assign_by_select_q;
	logic [flgt_pkg::OUT_IW-1:0] sel_tgt_q, idx_q;
	flgt_pkg::flgt_mode_t cfg_mode_q [NO];
	logic [flgt_pkg::FADER_AW-1:0] cfg_fader_q [NO];
	logic [LW-1:0] prev_q [NO];
	logic [7:0] pulse_cnt_q [NO];
	logic [16:0] tick_cnt_q;
	logic tick_q, rescan_q;
	flgt_scan_t scan_q;
	logic [LW-1:0] cur_lvl;
	logic [31:0] rd_val;
	logic hit, wr_en, cfg_page, eval;
	logic [flgt_pkg::OUT_IW-1:0] cfg_idx;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic [NO-1:0] gpo_o_q, gpo_oe_q;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign gpo_o = gpo_o_q;
	assign gpo_oe = gpo_oe_q;
	assign gpi_state = in_state_q;

	// apb slave
	assign cfg_idx = paddr[5:2];
	assign cfg_page = (paddr[7:6] == flgt_pkg::OFS_CFG_PAGE) && (cfg_idx < 4'(NO));
	assign wr_en = psel && penable && pready_q && pwrite && hit;

	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		if (cfg_page) begin
			rd_val[flgt_pkg::CFG_MODE_LSB +: 2] = cfg_mode_q[cfg_idx];
			rd_val[flgt_pkg::CFG_FADER_LSB +: flgt_pkg::FADER_AW] = cfg_fader_q[cfg_idx];
		end else begin
			case (paddr)
				flgt_pkg::OFS_IN_POL: rd_val[NI-1:0] = in_pol_q;
				flgt_pkg::OFS_IN_LATCH: rd_val[NI-1:0] = in_latch_q;
				flgt_pkg::OFS_IN_STATE: rd_val[NI-1:0] = in_state_q;
				flgt_pkg::OFS_OUT_POL: rd_val[NO-1:0] = out_pol_q;
				flgt_pkg::OFS_OUT_TEST: rd_val[NO-1:0] = out_test_q;
				flgt_pkg::OFS_OUT_STATE: rd_val[NO-1:0] = act_out;
				flgt_pkg::OFS_THRESH: begin
					rd_val[flgt_pkg::THR_UP_LSB +: LW] = thr_up_q;
					rd_val[flgt_pkg::THR_DN_LSB +: LW] = thr_dn_q;
				end
				flgt_pkg::OFS_SEL_CTRL: begin
					rd_val[flgt_pkg::SEL_EN_BIT] = assign_by_select_q;
					rd_val[flgt_pkg::SEL_TGT_LSB +: flgt_pkg::OUT_IW] = sel_tgt_q;
				end
				default: hit = 1'b0;
			endcase
		end
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end
	end

	// no wait state: answer is prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel && !penable;
			if (psel && !penable) begin
				pslverr_q <= !hit;
				prdata_q <= (pwrite || !hit) ? 32'h0000_0000 : rd_val;
			end
		end
	end

	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_pol_q <= flgt_pkg::RST_IN_POL;
			in_latch_q <= flgt_pkg::RST_IN_LATCH;
			out_pol_q <= flgt_pkg::RST_OUT_POL;
			out_test_q <= '0;
			thr_up_q <= flgt_pkg::RST_THR_UP;
			thr_dn_q <= flgt_pkg::RST_THR_DN;
			assign_by_select_q <= 1'b0;
			sel_tgt_q <= '0;
		end else if (wr_en && !cfg_page) begin
			case (paddr)
				flgt_pkg::OFS_IN_POL: in_pol_q <= pwdata[NI-1:0];
				flgt_pkg::OFS_IN_LATCH: in_latch_q <= pwdata[NI-1:0];
				flgt_pkg::OFS_OUT_POL: out_pol_q <= pwdata[NO-1:0];
				flgt_pkg::OFS_OUT_TEST: out_test_q <= pwdata[NO-1:0];
				flgt_pkg::OFS_THRESH: begin
					thr_up_q <= pwdata[flgt_pkg::THR_UP_LSB +: LW];
					thr_dn_q <= pwdata[flgt_pkg::THR_DN_LSB +: LW];
				end
				flgt_pkg::OFS_SEL_CTRL: begin
					assign_by_select_q <= pwdata[flgt_pkg::SEL_EN_BIT];
					sel_tgt_q <= pwdata[flgt_pkg::SEL_TGT_LSB +: flgt_pkg::OUT_IW];
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		for (int i = 0; i < NO; i++) begin
			cfg_wr[i] = wr_en && cfg_page && (cfg_idx == 4'(i));
		end
	end

	// per-output configuration; a bus write beats a select key in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NO; i++) begin
				cfg_mode_q[i] <= flgt_pkg::MODE_NONE;
				cfg_fader_q[i] <= '0;
			end
		end else begin
			if (assign_by_select_q && sel_key && (sel_tgt_q < 4'(NO))) begin
				cfg_fader_q[sel_tgt_q] <= sel_chan;
			end
			for (int i = 0; i < NO; i++) begin
				if (cfg_wr[i]) begin
					cfg_mode_q[i] <= flgt_pkg::flgt_mode_t'(pwdata[flgt_pkg::CFG_MODE_LSB +: 2]);
					cfg_fader_q[i] <= pwdata[flgt_pkg::CFG_FADER_LSB +: flgt_pkg::FADER_AW];
				end
			end
		end
	end

	// control inputs
	assign act_in = gpi_in ~^ in_pol_q;
	// latched inputs toggle on each press, momentary ones follow the switch
	assign in_state_d = (in_latch_q & (in_state_q ^ (act_in & ~act_prev_q)))
		| (~in_latch_q & act_in);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_prev_q <= '0;
			in_state_q <= '0;
		end else begin
			act_prev_q <= act_in;
			in_state_q <= in_state_d;
		end
	end

	// tick divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == 17'(TICK_CYCLES - 1));
			tick_cnt_q <= (tick_cnt_q == 17'(TICK_CYCLES - 1)) ? '0 : tick_cnt_q + 17'h1;
		end
	end

	// level scanner
	// one output per two cycles; a full pass takes 20 cycles, far inside a tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_q <= SCAN_IDLE;
			idx_q <= '0;
			rescan_q <= 1'b0;
		end else begin
			if (recall_pulse && scan_q != SCAN_IDLE) begin
				rescan_q <= 1'b1;
			end
			case (scan_q)
				SCAN_IDLE: begin
					if (tick_q || recall_pulse || rescan_q) begin
						scan_q <= SCAN_READ;
						idx_q <= '0;
						rescan_q <= 1'b0;
					end
				end
				SCAN_READ: scan_q <= SCAN_EVAL;
				SCAN_EVAL: begin
					if (idx_q == 4'(NO - 1)) begin
						scan_q <= SCAN_IDLE;
					end else begin
						idx_q <= idx_q + 4'h1;
						scan_q <= SCAN_READ;
					end
				end
				default: scan_q <= SCAN_IDLE;
			endcase
		end
	end

	assign eval = (scan_q == SCAN_EVAL);

	flgt_fader_mem u_mem (
		.pclk(pclk),
		.we(fader_we),
		.waddr(fader_addr),
		.wdata(fader_level),
		.rd_en(scan_q == SCAN_READ),
		.raddr(cfg_fader_q[idx_q]),
		.rdata_q(cur_lvl)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NO; i++) begin
				prev_q[i] <= '0;
			end
		end else if (eval) begin
			prev_q[idx_q] <= cur_lvl;
		end
	end

	// trigger generators
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tally_q <= '0;
			for (int i = 0; i < NO; i++) begin
				pulse_cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NO; i++) begin
				if (cfg_wr[i]) begin
					tally_q[i] <= 1'b0;
					pulse_cnt_q[i] <= '0;
				end else begin
					if (eval && idx_q == 4'(i) && (
						(cfg_mode_q[i] == flgt_pkg::MODE_START
						&& flgt_pkg::cross_up(prev_q[i], cur_lvl, thr_up_q)) ||
						(cfg_mode_q[i] == flgt_pkg::MODE_STOP
						&& flgt_pkg::reach_down(prev_q[i], cur_lvl, thr_dn_q)))) begin
						pulse_cnt_q[i] <= flgt_pkg::PULSE_TICKS;
					end else if (tick_q && pulse_cnt_q[i] != 8'h00) begin
						pulse_cnt_q[i] <= pulse_cnt_q[i] - 8'h01;
					end
					if (eval && idx_q == 4'(i) && cfg_mode_q[i] == flgt_pkg::MODE_TALLY) begin
						if (flgt_pkg::cross_up(prev_q[i], cur_lvl, thr_up_q)) begin
							tally_q[i] <= 1'b1;
						end else if (flgt_pkg::reach_down(prev_q[i], cur_lvl, thr_dn_q)) begin
							tally_q[i] <= 1'b0;
						end
					end
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NO; i++) begin
			pulse_on[i] = (pulse_cnt_q[i] != 8'h00);
		end
	end

	assign act_out = out_test_q | tally_q | pulse_on;

	// pin stays low-driven; only the enable moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpo_o_q <= '0;
			gpo_oe_q <= '0;
		end else begin
			gpo_o_q <= '0;
			gpo_oe_q <= act_out ^ out_pol_q;
		end
	end

	// assertions
	a_in_momentary: assert property (@(posedge pclk) disable iff (!presetn)
		$past(!in_latch_q[0]) |-> in_state_q[0] == ($past(gpi_in[0]) ~^ $past(in_pol_q[0])))
		else $error("momentary input state does not follow polarity");

	a_latch_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		in_latch_q[0] && act_in[0] && !act_prev_q[0] |=> in_state_q[0] != $past(in_state_q[0]))
		else $error("latched input did not toggle on press");

	a_test_force: assert property (@(posedge pclk) disable iff (!presetn)
		out_test_q[0] |=> gpo_oe_q[0] == !$past(out_pol_q[0]))
		else $error("test bit did not force output active");

	a_noassign_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_mode_q[0] == flgt_pkg::MODE_NONE && !tally_q[0] && !pulse_on[0] && !cfg_wr[0]
		|=> !tally_q[0] && !pulse_on[0])
		else $error("unassigned output produced a trigger");

	a_start_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		eval && idx_q == 4'h0 && !cfg_wr[0] && cfg_mode_q[0] == flgt_pkg::MODE_START
		&& flgt_pkg::cross_up(prev_q[0], cur_lvl, thr_up_q) |=> pulse_cnt_q[0] == 8'hfa)
		else $error("start crossing did not load pulse");

	a_stop_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		eval && idx_q == 4'h1 && !cfg_wr[1] && cfg_mode_q[1] == flgt_pkg::MODE_STOP
		&& flgt_pkg::reach_down(prev_q[1], cur_lvl, thr_dn_q)
		|=> pulse_on[1] ##1 gpo_oe_q[1] != $past(out_pol_q[1]))
		else $error("stop crossing did not assert output");
	a_start_up_only: assert property (@(posedge pclk) disable iff (!presetn)
		eval && idx_q == 4'h0 && cfg_mode_q[0] == flgt_pkg::MODE_START && pulse_cnt_q[0] == 8'h00
		&& !flgt_pkg::cross_up(prev_q[0], cur_lvl, thr_up_q) |=> pulse_cnt_q[0] == 8'h00)
		else $error("start mode fired without upward crossing");

	a_tally_hold: assert property (@(posedge pclk) disable iff (!presetn)
		tally_q[2] && !cfg_wr[2] && !(eval && idx_q == 4'h2) |=> tally_q[2])
		else $error("tally dropped without cause");

	a_pulse_count: assert property (@(posedge pclk) disable iff (!presetn)
		tick_q && pulse_on[0] && !eval && !cfg_wr[0] |=> pulse_cnt_q[0] == $past(pulse_cnt_q[0]) - 8'h01)
		else $error("pulse counter did not step on tick");

	a_sel_assign: assert property (@(posedge pclk) disable iff (!presetn)
		assign_by_select_q && sel_key && sel_tgt_q == 4'h3 && !cfg_wr[3]
		|=> cfg_fader_q[3] == $past(sel_chan))
		else $error("select key did not assign fader");

	a_recall_scan: assert property (@(posedge pclk) disable iff (!presetn)
		recall_pulse |-> ##[1:22] (scan_q == SCAN_READ && idx_q == 4'h0))
		else $error("recall did not start an evaluation pass");
endmodule

//--- sim/flgt_ext_model.sv
/*
 * Far-side model: a bank of control switches feeding the inputs, and the pull-up
 * of the receiving equipment on each open-drain control output.
 * Assumes switch changes are requested from a process synchronous to pclk.
 */
`timescale 1ns/1ps
module flgt_ext_model (
	input wire logic pclk,
	input wire logic [flgt_pkg::NUM_OUT-1:0] gpo_o,
	input wire logic [flgt_pkg::NUM_OUT-1:0] gpo_oe,
	output logic [flgt_pkg::NUM_IN-1:0] gpi_in,
	output logic [flgt_pkg::NUM_OUT-1:0] pin_lvl
);
	logic [flgt_pkg::NUM_IN-1:0] sw_q = '0;

	assign gpi_in = sw_q;
	// released pin floats up to the equipment's pull-up
	assign pin_lvl = (gpo_oe & gpo_o) | ~gpo_oe;

	task automatic set_sw(input logic [flgt_pkg::NUM_IN-1:0] v);
		@(posedge pclk);
		sw_q <= v;
	endtask
endmodule

//--- sim/testbench.sv
/*
 * Self-checking bench for the control port block: APB register access, input
 * polarity and latching, output polarity and test override, fader triggers.
 * Assumes a shortened tick so a 250-tick pulse fits a short run.
 */
`timescale 1ns/1ps
module testbench;
	localparam int TK = 30;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic fader_we = 0, recall_pulse = 0, sel_key = 0;
	logic [7:0] paddr = 0, fader_level = 0, gpi_in, gpi_state, lo, hi;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr;
	logic [9:0] gpo_o, gpo_oe, pin_lvl;
	logic [5:0] fader_addr = 0, sel_chan = 0, ch;
	logic [32:0] exp_q[$];
	int fails = 0, check_count = 0;

	always #4 pclk = ~pclk;

	flgt_top #(.TICK_CYCLES(TK)) flgt_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .gpi_in, .gpi_state, .gpo_o, .gpo_oe, .fader_we,
		.fader_addr, .fader_level, .recall_pulse, .sel_key, .sel_chan);
	flgt_ext_model flgt_ext_model_i (.pclk, .gpo_o, .gpo_oe, .gpi_in, .pin_lvl);

	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		check_count++;
		if (seen !== want) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// read expectations are noted here and matched by the monitor below
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		n = 0;
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		if (!w)
			exp_q.push_back(e);
		do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
		if (n >= 20)
			fails++;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		apb(a, 1'b0, 32'h0, e);
	endtask

	task automatic fw(input logic [5:0] a, input logic [7:0] l);
		fader_we <= 1;
		fader_addr <= a;
		fader_level <= l;
		@(posedge pclk);
		fader_we <= 0;
		@(posedge pclk);
	endtask

	task automatic sel(input logic [5:0] c);
		sel_key <= 1;
		sel_chan <= c;
		@(posedge pclk);
		sel_key <= 0;
		@(posedge pclk);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			chk({pslverr, prdata}, exp_q.pop_front());
	end

	// whole run is about 260 ticks plus register traffic
	initial begin
		#(8 * 30000);
		fails++;
		close_out();
	end

	initial begin
		void'($urandom(48365));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(8'h00, 33'h0ff);
		rd(8'h18, 33'h040);
		rd(8'h68, 33'h100000000);
		$display("test reset done");
		flgt_ext_model_i.set_sw(8'ha5);
		repeat (2) @(posedge pclk);
		rd(8'h08, 33'h0a5);
		wr(8'h00, 32'h0f);
		rd(8'h08, 33'h055);
		chk(33'(gpi_state), 33'h055);
		flgt_ext_model_i.set_sw(8'h00);
		wr(8'h00, 32'hff);
		wr(8'h04, 32'h01);
		for (int k = 0; k < 2; k++) begin
			flgt_ext_model_i.set_sw(8'h01);
			flgt_ext_model_i.set_sw(8'h00);
			repeat (2) @(posedge pclk);
			rd(8'h08, (k == 0) ? 33'h001 : 33'h000);
		end
		$display("test inputs done");
		wr(8'h10, 32'h001);
		repeat (3) @(posedge pclk);
		chk(33'(gpo_oe), 33'h001);
		chk(33'(pin_lvl), 33'h3fe);
		rd(8'h14, 33'h001);
		wr(8'h0c, 32'h003);
		repeat (3) @(posedge pclk);
		chk(33'(gpo_oe), 33'h002);
		wr(8'h0c, 32'h0);
		wr(8'h10, 32'h0);
		$display("test outputs done");
		lo = 8'($urandom_range(8'h21, 8'h3f));
		hi = 8'($urandom_range(8'h40, 8'hff));
		wr(8'h18, 32'h2040);
		fw(6'd0, lo);
		fw(6'd1, lo);
		wr(8'h40, 32'h001);
		wr(8'h44, 32'h002);
		wr(8'h50, 32'h000);
		repeat (2 * TK) @(posedge pclk);
		fw(6'd0, hi);
		repeat (2 * TK) @(posedge pclk);
		rd(8'h14, 33'h001);
		chk(33'(gpo_oe), 33'h001);
		repeat (245 * TK) @(posedge pclk);
		rd(8'h14, 33'h001);
		repeat (6 * TK) @(posedge pclk);
		rd(8'h14, 33'h000);
		fw(6'd0, 8'h10);
		repeat (2 * TK) @(posedge pclk);
		rd(8'h14, 33'h002);
		$display("test start stop done");
		wr(8'h48, 32'h103);
		repeat (2 * TK) @(posedge pclk);
		fw(6'd1, hi);
		recall_pulse <= 1;
		@(posedge pclk);
		recall_pulse <= 0;
		repeat (24) @(posedge pclk);
		rd(8'h14, 33'h006);
		fw(6'd1, 8'h10);
		repeat (2 * TK) @(posedge pclk);
		rd(8'h14, 33'h002);
		fw(6'd1, hi);
		repeat (2 * TK) @(posedge pclk);
		rd(8'h14, 33'h006);
		wr(8'h48, 32'h103);
		repeat (3) @(posedge pclk);
		rd(8'h14, 33'h002);
		$display("test tally done");
		ch = 6'($urandom_range(1, 63));
		wr(8'h1c, 32'h301);
		sel(ch);
		rd(8'h4c, {19'h0, ch, 8'h00});
		wr(8'h1c, 32'h0);
		sel(~ch);
		rd(8'h4c, {19'h0, ch, 8'h00});
		$display("test select done");
		close_out();
	end
endmodule
